/* File: core/boundary_scan_tap.sv */
// Boundary scan test access port: controller, instruction decoder, data
// chains, pin test cells and internal register access.
// Assumes pins arrive asynchronously and are sampled by clk_i.
// Behaviour
// [RL1] Codes 0,1,2,3,4,5,7,8,9,10 decode to bypass, sample, id, user, clamp, high-Z, extest, interface toggle, read and write.
// [RL2] Register write shifts 7 address bits then 8 data bits; register read takes a 7-bit address and returns 8 data bits.
// [RL3] The port has three inputs (clock, mode select, data in) and one output (data out) forming the scan path.
// [RL4] All test state moves only on test clock edges and holds while that clock stands still.
// [RL5] Mode select is sampled on each rising test clock edge to choose the next state.
// [RL6] The outside controller changes mode select and data in on the falling test clock edge.
// [RL7] Five rising edges with mode select high put the controller in Test-Logic-Reset from anywhere.
// [RL8] Entering Test-Logic-Reset loads the identification instruction.
// [RL9] Data in is sampled on the rising edge into the instruction chain or the selected data chain.
// [RL10] Data out shows the serial end of the instruction chain or of the selected data chain.
// [RL11] Each pin has a test cell that overrides its normal function under test instructions.
// [RL12] Data out is not driven unless the port is shifting.
// [RL13] Data out changes on the falling test clock edge.
// [RL14] The interface toggle instruction with a 1 at Update-DR disables the host interfaces and enables register access.
// [RL15] Register read captures the current address, shifts in a new one and makes it current at Update-DR.
// [RL16] The controller is the standard sixteen-state machine with capture, shift and update for both paths.
// [RL17] Bypass puts one flip-flop between data in and data out.
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_tap
#(
  parameter logic [31:0] ID_VALUE = 32'h1000_0001,  // Arbitrary value
  parameter logic [31:0] USER_VALUE = 32'h0000_0000,  // Arbitrary value
  parameter int PINS = tap_pkg::PIN_COUNT
)
(
  // System
  input wire logic clk_i,
  input wire logic reset_i,
  // Test link
  input wire logic test_clk_i,
  input wire logic mode_sel_i,
  input wire logic data_in_i,
  output logic data_out_o,
  output logic data_out_oe_o,
  // Pins: core side
  input wire logic [PINS-1:0] core_out_i,
  input wire logic [PINS-1:0] core_oe_i,
  output logic [PINS-1:0] core_in_o,
  // Pins: pad side
  input wire logic [PINS-1:0] pad_in_i,
  output logic [PINS-1:0] pad_out_o,
  output logic [PINS-1:0] pad_oe_o,
  // Internal register access
  output logic host_disable_o,
  output tap_pkg::reg_access_type reg_req_o,
  output logic reg_req_valid_o,
  input wire logic [7:0] reg_rdata_i
);

  localparam int CW = tap_pkg::CHAIN_WIDTH;
  localparam int IW = tap_pkg::IR_WIDTH;
  localparam int RW = tap_pkg::ADDR_WIDTH + tap_pkg::DATA_WIDTH;

  tap_pkg::link_in_type pins;
  tap_pkg::link_event_type ev;

  tap_pkg::tap_state_type state, next_state;
  logic [IW-1:0] ir_shift, next_ir_shift, ir, next_ir;
  logic [31:0] dr_shift, next_dr_shift;
  logic [CW-1:0] bs_update, next_bs_update;
  logic [6:0] cur_addr, next_cur_addr;
  logic host_off, next_host_off;
  logic tdo, next_tdo, tdo_en, next_tdo_en;
  tap_pkg::reg_access_type req, next_req;
  logic req_valid, next_req_valid;
  logic [2:0] ones, next_ones;
  logic [CW-1:0] capture_vec;
  logic test_mode;

  assign pins.tck = test_clk_i; // RL3
  assign pins.tms = mode_sel_i; // RL3
  assign pins.tdi = data_in_i; // RL3

  link_sync u_sync
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pins_i(pins),
    .event_o(ev)
  );

  // Length of the data chain chosen by an instruction
  function automatic int dr_len(input logic [IW-1:0] code);
    case (code)
      tap_pkg::INS_SAMPLE, tap_pkg::INS_EXTEST: dr_len = CW;
      tap_pkg::INS_IDCODE, tap_pkg::INS_USERCODE: dr_len = 32;
      tap_pkg::INS_IFACE: dr_len = 1;
      tap_pkg::INS_REG_READ: dr_len = RW; // RL2
      tap_pkg::INS_REG_WRITE: dr_len = RW;
      default: dr_len = 1;
    endcase
  endfunction : dr_len

  // Standard controller transitions
  function automatic tap_pkg::tap_state_type advance(
    input tap_pkg::tap_state_type s, input logic m);
    case (s)
      tap_pkg::ST_RESET: advance = m ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
      tap_pkg::ST_IDLE: advance = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
      tap_pkg::ST_SEL_DR: advance = m ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
      tap_pkg::ST_CAP_DR:
        advance = m ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_SHIFT_DR:
        advance = m ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_EXIT1_DR:
        advance = m ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
      tap_pkg::ST_PAUSE_DR:
        advance = m ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
      tap_pkg::ST_EXIT2_DR:
        advance = m ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_UPD_DR: advance = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
      tap_pkg::ST_SEL_IR: advance = m ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
      tap_pkg::ST_CAP_IR:
        advance = m ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_SHIFT_IR:
        advance = m ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_EXIT1_IR:
        advance = m ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
      tap_pkg::ST_PAUSE_IR:
        advance = m ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
      tap_pkg::ST_EXIT2_IR:
        advance = m ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_UPD_IR: advance = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
      default: advance = tap_pkg::ST_RESET;
    endcase
  endfunction : advance

  // Capture vector: pin input and output enable per cell pair, zero padded
  always_comb
  begin
    capture_vec = '0;
    for (int i = 0; i < PINS && 2 * i + 1 < CW; i++)
    begin
      capture_vec[2 * i] = pad_in_i[i];
      capture_vec[2 * i + 1] = core_oe_i[i];
    end
  end

  always_comb
  begin
    int len;
    len = dr_len(ir);
    next_state = state;
    next_ir_shift = ir_shift;
    next_ir = ir;
    next_dr_shift = dr_shift;
    next_bs_update = bs_update;
    next_cur_addr = cur_addr;
    next_host_off = host_off;
    next_tdo = tdo;
    next_tdo_en = tdo_en;
    next_req = req;
    next_req_valid = 1'b0;
    next_ones = ones;
    if (ev.rise) // RL4
    begin
      next_state = advance(state, ev.tms); // RL5 RL16
      next_ones = ev.tms ? ((ones == 3'(tap_pkg::RESET_ONES)) ? ones
                            : ones + 3'h1) : 3'h0;
      if (ev.tms && ones == 3'(tap_pkg::RESET_ONES - 1))
        next_state = tap_pkg::ST_RESET; // RL7
      case (state)
        tap_pkg::ST_RESET:
        begin
          next_ir = tap_pkg::INS_IDCODE; // RL8
          next_host_off = 1'b0;
        end
        tap_pkg::ST_CAP_IR:
          next_ir_shift = 4'h1;
        tap_pkg::ST_SHIFT_IR:
          next_ir_shift = {ev.tdi, ir_shift[IW-1:1]}; // RL9
        tap_pkg::ST_UPD_IR:
          next_ir = ir_shift; // RL1
        tap_pkg::ST_CAP_DR:
        begin
          case (ir)
            tap_pkg::INS_SAMPLE, tap_pkg::INS_EXTEST:
              next_dr_shift = {8'h00, capture_vec}; // RL11
            tap_pkg::INS_IDCODE:
              next_dr_shift = ID_VALUE;
            tap_pkg::INS_USERCODE:
              next_dr_shift = USER_VALUE;
            tap_pkg::INS_IFACE:
              next_dr_shift = {31'h0, host_off};
            tap_pkg::INS_REG_READ:
              next_dr_shift = {17'h0, reg_rdata_i, cur_addr}; // RL15
            default:
              next_dr_shift = '0; // RL17
          endcase
        end
        tap_pkg::ST_SHIFT_DR:
        begin
          // Data in enters at the top bit of the chosen chain length
          next_dr_shift = dr_shift >> 1; // RL9
          next_dr_shift[len - 1] = ev.tdi;
        end
        tap_pkg::ST_UPD_DR:
        begin
          case (ir)
            tap_pkg::INS_SAMPLE, tap_pkg::INS_EXTEST:
              next_bs_update = dr_shift[CW-1:0];
            tap_pkg::INS_IFACE:
              next_host_off = dr_shift[0]; // RL14
            tap_pkg::INS_REG_READ:
              if (host_off)
              begin
                next_cur_addr = dr_shift[6:0]; // RL15
                next_req.addr = dr_shift[6:0];
                next_req.data = 8'h00;
                next_req.write = 1'b0;
                next_req_valid = 1'b1;
              end
            tap_pkg::INS_REG_WRITE:
              if (host_off)
              begin
                next_req.addr = dr_shift[6:0]; // RL2
                next_req.data = dr_shift[14:7];
                next_req.write = 1'b1;
                next_req_valid = 1'b1;
              end
            default:
              next_req_valid = 1'b0;
          endcase
        end
        default:
          next_req_valid = 1'b0;
      endcase
      // Test-Logic-Reset takes over at the very rise that enters it
      if (next_state == tap_pkg::ST_RESET)
      begin
        next_ir = tap_pkg::INS_IDCODE; // RL8
        next_host_off = 1'b0;
      end
    end
    if (ev.fall) // RL13
    begin
      next_tdo_en = (state == tap_pkg::ST_SHIFT_IR)
                    || (state == tap_pkg::ST_SHIFT_DR); // RL12
      next_tdo = (state == tap_pkg::ST_SHIFT_IR) ? ir_shift[0]
                 : dr_shift[0]; // RL10
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state <= tap_pkg::ST_RESET;
      ir_shift <= '0;
      ir <= tap_pkg::INS_IDCODE;
      dr_shift <= '0;
      bs_update <= '0;
      cur_addr <= '0;
      host_off <= 1'b0;
      tdo <= 1'b0;
      tdo_en <= 1'b0;
      req <= '0;
      req_valid <= 1'b0;
      ones <= '0;
    end
    else
    begin
      state <= next_state;
      ir_shift <= next_ir_shift;
      ir <= next_ir;
      dr_shift <= next_dr_shift;
      bs_update <= next_bs_update;
      cur_addr <= next_cur_addr;
      host_off <= next_host_off;
      tdo <= next_tdo;
      tdo_en <= next_tdo_en;
      req <= next_req;
      req_valid <= next_req_valid;
      ones <= next_ones;
    end
  end

  // Pin test cells take over under extest, clamp and high-Z
  assign test_mode = (ir == tap_pkg::INS_EXTEST) || (ir == tap_pkg::INS_CLAMP)
                     || (ir == tap_pkg::INS_HIGHZ);

  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      if (ir == tap_pkg::INS_HIGHZ)
      begin
        pad_out_o[i] = 1'b0;
        pad_oe_o[i] = 1'b0;
      end
      else if (test_mode && 2 * i + 1 < CW) // RL11
      begin
        pad_out_o[i] = bs_update[2 * i];
        pad_oe_o[i] = bs_update[2 * i + 1];
      end
      else
      begin
        pad_out_o[i] = core_out_i[i];
        pad_oe_o[i] = core_oe_i[i];
      end
      core_in_o[i] = pad_in_i[i];
    end
  end

  assign data_out_o = tdo;
  assign data_out_oe_o = tdo_en;
  assign host_disable_o = host_off;
  assign reg_req_o = req;
  assign reg_req_valid_o = req_valid;

endmodule : boundary_scan_tap
`default_nettype wire

/* File: shared/tap_pkg.sv */
// Constants, state encoding and carrier types for the boundary scan port.
// Assumes a single system clock; the test clock is sampled as data.
package tap_pkg;

  localparam int IR_WIDTH = 4;
  localparam int CHAIN_WIDTH = 24;
  localparam int ID_WIDTH = 32;
  localparam int ADDR_WIDTH = 7;
  localparam int DATA_WIDTH = 8;
  localparam int RESET_ONES = 5;
  localparam int PIN_COUNT = 8;

  localparam logic [3:0] INS_BYPASS = 4'h0;
  localparam logic [3:0] INS_SAMPLE = 4'h1;
  localparam logic [3:0] INS_IDCODE = 4'h2;
  localparam logic [3:0] INS_USERCODE = 4'h3;
  localparam logic [3:0] INS_CLAMP = 4'h4;
  localparam logic [3:0] INS_HIGHZ = 4'h5;
  localparam logic [3:0] INS_EXTEST = 4'h7;
  localparam logic [3:0] INS_IFACE = 4'h8;
  localparam logic [3:0] INS_REG_READ = 4'h9;
  localparam logic [3:0] INS_REG_WRITE = 4'hA;

  // Gray codes along reset, idle, DR path
  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SHIFT_DR = 4'h6,
    ST_EXIT1_DR = 4'h7,
    ST_PAUSE_DR = 4'h5,
    ST_EXIT2_DR = 4'h4,
    ST_UPD_DR = 4'hC,
    ST_SEL_IR = 4'hD,
    ST_CAP_IR = 4'hF,
    ST_SHIFT_IR = 4'hE,
    ST_EXIT1_IR = 4'hA,
    ST_PAUSE_IR = 4'hB,
    ST_EXIT2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } tap_state_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } link_in_type;

  typedef struct packed {
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
  } link_event_type;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic write;
  } reg_access_type;

endpackage : tap_pkg

/* File: core/link_sync.sv */
// Synchroniser and edge finder for the test clock, mode select and data in.
// Assumes the link pins are asynchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module link_sync
(
  // System
  input wire logic clk_i,
  input wire logic reset_i,
  // Pins
  input wire tap_pkg::link_in_type pins_i,
  // Events
  output tap_pkg::link_event_type event_o
);

  tap_pkg::link_in_type stage1, stage2, stage3;
  tap_pkg::link_in_type next_stage1, next_stage2, next_stage3;
  logic tck_level, tms_level, tdi_level;
  logic next_tck_level, next_tms_level, next_tdi_level;
  tap_pkg::link_event_type next_event;

  // A change counts once the second and third stages agree
  always_comb
  begin
    next_stage1 = pins_i;
    next_stage2 = stage1;
    next_stage3 = stage2;
    next_tck_level = (stage2.tck == stage3.tck) ? stage3.tck : tck_level;
    next_tms_level = (stage2.tms == stage3.tms) ? stage3.tms : tms_level;
    next_tdi_level = (stage2.tdi == stage3.tdi) ? stage3.tdi : tdi_level;
    next_event.rise = next_tck_level & ~tck_level;
    next_event.fall = ~next_tck_level & tck_level;
    next_event.tms = tms_level;
    next_event.tdi = tdi_level;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
      tck_level <= 1'b1;
      tms_level <= 1'b1;
      tdi_level <= 1'b1;
      event_o <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
      tck_level <= next_tck_level;
      tms_level <= next_tms_level;
      tdi_level <= next_tdi_level;
      event_o <= next_event;
    end
  end

endmodule : link_sync
`default_nettype wire

/* File: tb/boundary_scan_tap_chk.sv */
// Port checker for the boundary scan port.
// Bound to boundary_scan_tap; sees its ports only, single clock domain.
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_tap_chk
(
  // System
  input wire logic clk_i,
  input wire logic reset_i,
  // Link and outputs
  input wire logic test_clk_i,
  input wire logic data_out_o,
  input wire logic data_out_oe_o,
  input wire logic host_disable_o,
  input wire tap_pkg::reg_access_type reg_req_o,
  input wire logic reg_req_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence link_still;
    $stable(test_clk_i) [*8];
  endsequence
  sequence req_pulse;
    reg_req_valid_o ##1 !reg_req_valid_o;
  endsequence

  reset_quiet_a: assert property ($fell(reset_i) |->
    !data_out_oe_o && !host_disable_o && !reg_req_valid_o)
    else $error("outputs active after reset");
  out_on_fall_a: assert property (!$stable(data_out_o) |-> !test_clk_i)
    else $error("data out moved outside low phase");
  oe_on_fall_a: assert property (!$stable(data_out_oe_o) |-> !test_clk_i)
    else $error("out enable moved outside low phase");
  req_one_pulse_a: assert property (reg_req_valid_o |-> req_pulse)
    else $error("request valid longer than one cycle");
  req_enabled_a: assert property (reg_req_valid_o |-> host_disable_o)
    else $error("request while register access off");
  req_held_a: assert property (!$stable(reg_req_o) |-> reg_req_valid_o)
    else $error("request changed without valid");
  host_on_update_a: assert property (!$stable(host_disable_o) |->
    test_clk_i)
    else $error("host disable moved outside high phase");
  link_hold_a: assert property (link_still |=>
    $stable({data_out_o, data_out_oe_o, host_disable_o}) && !reg_req_valid_o)
    else $error("outputs moved with test clock stopped");
endmodule : boundary_scan_tap_chk

bind boundary_scan_tap boundary_scan_tap_chk i_chk
(
  .clk_i(clk_i),
  .reset_i(reset_i),
  .test_clk_i(test_clk_i),
  .data_out_o(data_out_o),
  .data_out_oe_o(data_out_oe_o),
  .host_disable_o(host_disable_o),
  .reg_req_o(reg_req_o),
  .reg_req_valid_o(reg_req_valid_o)
);
`default_nettype wire

/* File: tb/scan_master.sv */
// Model of the external scan controller driving the four-wire link.
// Assumes the device samples at the rise and updates data out at the fall.
`timescale 1ns/10ps
`default_nettype none
module scan_master
(
  // Link
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // Clock stands high between frames, as the pull-up leaves it
  initial
  begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One 64 ns test clock cycle; data out is read just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tck_o = 1'b0;
    tms_o = m;
    tdi_o = d;
    #32;
    q = tdo_i;
    tck_o = 1'b1;
    #32;
  endtask : step

  task automatic to_idle();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : to_idle

  // From idle through one scan of n bits, LSB first, and back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan
endmodule : scan_master
`default_nettype wire

/* File: tb/test_boundary_scan_tap.sv */
// Self-checking bench for the boundary scan port.
// Link driven by scan_master; pins and read data driven here.
`timescale 1ns/10ps
`default_nettype none
module test_boundary_scan_tap;
  localparam logic [31:0] ID = 32'h1234_5671;  // Arbitrary value
  localparam logic [31:0] USER = 32'h0BAD_F00D;  // Arbitrary value
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, host_off, req_valid;
  logic [7:0] core_out = 8'h96;
  logic [7:0] core_oe = 8'hC3;
  logic [7:0] pad_in = 8'h5A;
  logic [7:0] rdata = 8'h3C;
  logic [7:0] core_in, pad_out, pad_oe;
  tap_pkg::reg_access_type req, last_req;
  int errors = 0;
  int comparisons = 0;
  int reqs = 0;
  int cycles = 0;
  logic [31:0] got;

  always #2.5 clk_i = ~clk_i;

  boundary_scan_tap #(.ID_VALUE(ID), .USER_VALUE(USER)) i_dut
  (
    .clk_i(clk_i), .reset_i(reset_i),
    .test_clk_i(tck), .mode_sel_i(tms), .data_in_i(tdi),
    .data_out_o(tdo), .data_out_oe_o(tdo_oe),
    .core_out_i(core_out), .core_oe_i(core_oe), .core_in_o(core_in),
    .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
    .host_disable_o(host_off), .reg_req_o(req),
    .reg_req_valid_o(req_valid), .reg_rdata_i(rdata)
  );
  // Released data out reads as the inverse, so a late enable shows up
  scan_master i_master
  (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo_oe ? tdo : ~tdo)
  );

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (req_valid)
    begin
      reqs <= reqs + 1;
      last_req <= req;
    end
    if (cycles == 60000)
    begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e,
                       input string m);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask : check

  task automatic t_id();
    logic q;
    i_master.to_idle();
    repeat (100) @(posedge clk_i);
    check(tdo_oe, 1'b0, "oe idle");
    i_master.scan(1'b0, '0, 32, got);
    check(got, ID, "id");
    i_master.scan(1'b1, 32'h3, 4, got);
    i_master.scan(1'b0, '0, 32, got);
    check(got, USER, "user code");
    i_master.step(1'b1, 1'b1, q);
    repeat (2) i_master.step(1'b0, 1'b1, q);
    repeat (5) i_master.step(1'b0, 1'b0, q);
    check(tdo_oe, 1'b1, "oe shifting");
    i_master.to_idle();
    i_master.scan(1'b0, '0, 32, got);
    check(got, ID, "id after mid-shift reset");
    $display("id test done");
  endtask : t_id

  task automatic t_ir();
    logic [3:0] code [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7,
      4'h8, 4'h9, 4'hA};
    int len [10] = '{1, 24, 0, 0, 0, 0, 24, 1, 15, 15};
    for (int k = 0; k < 10; k++)
    begin
      i_master.scan(1'b1, {28'h0, code[k]}, 4, got);
      check(got[3:0], 4'h1, "ir capture");
      if (len[k] > 0)
      begin
        i_master.scan(1'b0, 32'h1, 32, got);
        check(got >> len[k], 32'h1, "chain length");
      end
    end
    $display("instruction test done");
  endtask : t_ir

  task automatic t_pins();
    logic [31:0] p = 32'h00A6_C93B;
    logic [15:0] cap;
    logic [7:0] eo, ee;
    logic [7:0] pv = 8'hA5;
    @(posedge clk_i) pad_in <= pv;
    for (int i = 0; i < 8; i++)
    begin
      eo[i] = p[2 * i];
      ee[i] = p[2 * i + 1];
      cap[2 * i] = pv[i];
      cap[2 * i + 1] = core_oe[i];
    end
    i_master.scan(1'b1, 32'h1, 4, got);
    i_master.scan(1'b0, p, 24, got);
    check(got[15:0], cap, "sample capture");
    i_master.scan(1'b1, 32'h7, 4, got);
    repeat (10) @(posedge clk_i);
    check({pad_oe, pad_out}, {ee, eo}, "extest");
    i_master.scan(1'b1, 32'h5, 4, got);
    repeat (10) @(posedge clk_i);
    check(pad_oe, 8'h00, "high-z");
    i_master.scan(1'b1, 32'h4, 4, got);
    repeat (10) @(posedge clk_i);
    check({pad_oe, pad_out}, {ee, eo}, "clamp");
    i_master.scan(1'b1, 32'h0, 4, got);
    repeat (10) @(posedge clk_i);
    check({pad_oe, pad_out, core_in}, {core_oe, core_out, pad_in}, "normal");
    $display("pin test done");
  endtask : t_pins

  task automatic t_reg();
    int n0 = reqs;
    i_master.scan(1'b1, 32'hA, 4, got);
    i_master.scan(1'b0, 32'h5A55, 15, got);
    repeat (10) @(posedge clk_i);
    check(reqs, n0, "write refused");
    i_master.scan(1'b1, 32'h8, 4, got);
    i_master.scan(1'b0, 32'h1, 1, got);
    repeat (10) @(posedge clk_i);
    check(host_off, 1'b1, "host off");
    i_master.scan(1'b1, 32'hA, 4, got);
    i_master.scan(1'b0, {17'h0, 8'hC5, 7'h2D}, 15, got);
    repeat (10) @(posedge clk_i);
    check(reqs, n0 + 1, "one write");
    check(last_req, {7'h2D, 8'hC5, 1'b1}, "write request");
    i_master.scan(1'b1, 32'h9, 4, got);
    i_master.scan(1'b0, 32'h53, 15, got);
    repeat (10) @(posedge clk_i);
    check({last_req.addr, last_req.write}, {7'h53, 1'b0}, "read");
    i_master.scan(1'b0, 32'h0, 15, got);
    check(got[6:0], 7'h53, "address capture");
    check(got[14:7], 8'h3C, "read data");
    $display("register test done");
  endtask : t_reg

  task automatic summarize();
    $display("%0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    t_id();
    t_ir();
    t_pins();
    t_reg();
    summarize();
  end
endmodule : test_boundary_scan_tap
`default_nettype wire
